// >>> core/display_reload_regs.vh
`ifndef DISPLAY_RELOAD_REGS_VH
`define DISPLAY_RELOAD_REGS_VH

// Register byte offsets
`define OFS_COUNTER_RELOAD    8'h00
`define OFS_DMA_REQUEST_COUNT 8'h04
`define OFS_CLIP_BOUNDS       8'h08
`define OFS_DISPLAY_CTRL      8'h0C
`define OFS_REQUEST_STATUS    8'h10
`define OFS_COUNTER_STATUS    8'h14

// Writable bit masks, reserved bits stay zero
`define MASK_COUNTER_RELOAD    32'h0FFFFFFF
`define MASK_DMA_REQUEST_COUNT 32'h0FFF0FFF
`define MASK_DISPLAY_CTRL      32'h0000000F

// Reset values
`define RST_COUNTER_RELOAD    32'h00000000
`define RST_DMA_REQUEST_COUNT 32'h00000000
`define RST_CLIP_BOUNDS       32'hF010EB10
`define RST_DISPLAY_CTRL      32'h00000000

// Field positions
`define LINE_RELOAD_MSB  27
`define LINE_RELOAD_LSB  16
`define CLOCK_RELOAD_MSB 15
`define CLOCK_RELOAD_LSB 12
`define PIXEL_RELOAD_MSB 11
`define PIXEL_RELOAD_LSB 0
`define FIELD2_CNT_MSB   27
`define FIELD2_CNT_LSB   16
`define FIELD1_CNT_MSB   11
`define FIELD1_CNT_LSB   0
`define CHROMA_HI_MSB    31
`define CHROMA_HI_LSB    24
`define CHROMA_LO_MSB    23
`define CHROMA_LO_LSB    16
`define LUMA_HI_MSB      15
`define LUMA_HI_LSB      8
`define LUMA_LO_MSB      7
`define LUMA_LO_LSB      0
`define CTRL_MODE_MSB    1
`define CTRL_MODE_LSB    0
`define CTRL_EXT_HSYNC   2
`define CTRL_EXT_VSYNC   3

// Display modes
`define MODE_BT656 2'h0
`define MODE_YC    2'h1
`define MODE_RAW   2'h2

`endif

// >>> core/display_reload_event_clip.v
`timescale 1ns/1ps
`default_nettype none
`include "display_reload_regs.vh"

module display_reload_event_clip #(
    parameter LINE_PIXELS = 12'd858,
    parameter FRAME_LINES = 12'd525
) (
    // Clock and reset
    input  wire        ref_clk_i,
    input  wire        resetn_i,

    // Register bus
    input  wire [7:0]  paddr_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,

    // Video timing pins
    input  wire        vid_clk_i,
    input  wire        ext_hsync_i,
    input  wire        ext_vsync_i,

    // Field and DMA request handshake
    input  wire        field_start_i,
    input  wire        field2_i,
    input  wire        dma_need_i,
    output reg         luma_dma_request_o,
    output reg         blue_chroma_dma_request_o,
    output reg         red_chroma_dma_request_o,

    // Pixel stream
    input  wire [9:0]  pix_data_i,
    input  wire        pix_chroma_i,
    input  wire        pix_image_i,
    input  wire        pix_valid_i,
    output reg  [9:0]  pix_data_o,
    output reg         pix_valid_o
);

    // Software-visible registers
    reg  [31:0] display_counter_reload_r;
    reg  [31:0] display_dma_request_count_r;
    reg  [31:0] output_clip_bounds_r;
    reg  [31:0] display_ctrl_r;

    // Display counters and request budget
    reg  [11:0] frame_line_counter_r;
    reg  [3:0]  video_clock_counter_r;
    reg  [11:0] frame_pixel_counter_r;
    reg  [11:0] requests_left_r;
    reg         field2_active_r;

    // Pin synchroniser stages
    reg  [2:0]  vclk_sync_r;
    reg  [2:0]  hsync_sync_r;
    reg  [2:0]  vsync_sync_r;

    // Combinational results
    reg  [31:0] rdata_nxt;
    reg         unmapped_nxt;
    reg  [7:0]  clamp8_nxt;
    reg         clamped_nxt;

    // Decode and datapath helpers
    wire [1:0]  mode;
    wire        raw_mode;
    wire        vclk_rise;
    wire        hsync_rise;
    wire        vsync_rise;
    wire        hsync_load;
    wire        vsync_load;
    wire        apb_access;
    wire        apb_write;
    wire [7:0]  lo_bound;
    wire [7:0]  hi_bound;
    wire [7:0]  sample8;
    wire        clip_active;
    wire        pixel_wrap;
    wire        line_wrap;
    wire        apb_first;
    wire        need_taken;

    // Mode decode; code 3 behaves as a non-raw mode
    assign mode     = display_ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
    assign raw_mode = (mode == `MODE_RAW);

    // Wrap points of the free-running counters
    assign pixel_wrap = (frame_pixel_counter_r >= LINE_PIXELS - 12'd1);
    assign line_wrap  = (frame_line_counter_r >= FRAME_LINES - 12'd1);

    // Pin synchronisers; edges found between second and third stage
    // Only the second stage reads the first, which may be metastable
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            vclk_sync_r  <= 3'h0;
            hsync_sync_r <= 3'h0;
            vsync_sync_r <= 3'h0;
        end else begin
            vclk_sync_r  <= {vclk_sync_r[1:0], vid_clk_i};
            hsync_sync_r <= {hsync_sync_r[1:0], ext_hsync_i};
            vsync_sync_r <= {vsync_sync_r[1:0], ext_vsync_i};
        end
    end

    assign vclk_rise  = vclk_sync_r[1] & ~vclk_sync_r[2];
    assign hsync_rise = hsync_sync_r[1] & ~hsync_sync_r[2];
    assign vsync_rise = vsync_sync_r[1] & ~vsync_sync_r[2];

    // Reloads only act with the matching external sync selected
    assign hsync_load = hsync_rise & display_ctrl_r[`CTRL_EXT_HSYNC];
    assign vsync_load = vsync_rise & display_ctrl_r[`CTRL_EXT_VSYNC];

    // APB: one wait state, write commits when pready is high
    // The answer edge is the only edge that commits a write
    assign apb_access = psel_i & penable_i;
    assign apb_first  = apb_access & ~pready_o;
    assign apb_write  = apb_access & pready_o & pwrite_i;

    // Read mux and address decode
    always @* begin
        rdata_nxt    = 32'h00000000;
        unmapped_nxt = 1'b0;
        case (paddr_i)
            `OFS_COUNTER_RELOAD:    rdata_nxt = display_counter_reload_r;
            `OFS_DMA_REQUEST_COUNT: rdata_nxt = display_dma_request_count_r;
            `OFS_CLIP_BOUNDS:       rdata_nxt = output_clip_bounds_r;
            `OFS_DISPLAY_CTRL:      rdata_nxt = display_ctrl_r;
            `OFS_REQUEST_STATUS:    rdata_nxt = {19'h0, field2_active_r,
                                                 requests_left_r};
            `OFS_COUNTER_STATUS:    rdata_nxt = {4'h0, frame_line_counter_r,
                                                 video_clock_counter_r,
                                                 frame_pixel_counter_r};
            default:                unmapped_nxt = 1'b1;
        endcase
    end

    // Bus handshake and read data
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else if (apb_first) begin
            pready_o  <= 1'b1;
            prdata_o  <= pwrite_i ? 32'h00000000 : rdata_nxt;
            pslverr_o <= unmapped_nxt;
        end else begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h00000000;
            pslverr_o <= 1'b0;
        end
    end

    // Software registers; reserved bits masked off
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            display_counter_reload_r    <= `RST_COUNTER_RELOAD;
            display_dma_request_count_r <= `RST_DMA_REQUEST_COUNT;
            output_clip_bounds_r        <= `RST_CLIP_BOUNDS;
            display_ctrl_r              <= `RST_DISPLAY_CTRL;
        end else if (apb_write) begin
            case (paddr_i)
                `OFS_COUNTER_RELOAD:
                    display_counter_reload_r <= pwdata_i & `MASK_COUNTER_RELOAD;
                `OFS_DMA_REQUEST_COUNT:
                    display_dma_request_count_r <= pwdata_i & `MASK_DMA_REQUEST_COUNT;
                `OFS_CLIP_BOUNDS:
                    output_clip_bounds_r <= pwdata_i;
                `OFS_DISPLAY_CTRL:
                    display_ctrl_r <= pwdata_i & `MASK_DISPLAY_CTRL;
                default: begin
                end
            endcase
        end
    end

    // Display counters; a sync reload wins over counting
    // An hsync reload also stops line counting for that cycle; a vsync reload still loads it
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            frame_line_counter_r  <= 12'h000;
            video_clock_counter_r <= 4'h0;
            frame_pixel_counter_r <= 12'h000;
        end else begin
            if (hsync_load) begin
                video_clock_counter_r <= display_counter_reload_r
                    [`CLOCK_RELOAD_MSB:`CLOCK_RELOAD_LSB];
                frame_pixel_counter_r <= display_counter_reload_r
                    [`PIXEL_RELOAD_MSB:`PIXEL_RELOAD_LSB];
            end else if (vclk_rise) begin
                video_clock_counter_r <= video_clock_counter_r + 4'h1;
                if (pixel_wrap)
                    frame_pixel_counter_r <= 12'h000;
                else
                    frame_pixel_counter_r <= frame_pixel_counter_r + 12'h001;
            end
            if (vsync_load) begin
                frame_line_counter_r <= display_counter_reload_r
                    [`LINE_RELOAD_MSB:`LINE_RELOAD_LSB];
            end else if (vclk_rise && !hsync_load && pixel_wrap) begin
                if (line_wrap)
                    frame_line_counter_r <= 12'h000;
                else
                    frame_line_counter_r <= frame_line_counter_r + 12'h001;
            end
        end
    end

    // A need pulse is served while budget is left
    assign need_taken = dma_need_i & (requests_left_r != 12'h000);

    // Request budget per field, one set per need cycle; raw mode sets luma only
    // Need pulses in the field start cycle are dropped
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            requests_left_r           <= 12'h000;
            field2_active_r           <= 1'b0;
            luma_dma_request_o        <= 1'b0;
            blue_chroma_dma_request_o <= 1'b0;
            red_chroma_dma_request_o  <= 1'b0;
        end else begin
            luma_dma_request_o        <= 1'b0;
            blue_chroma_dma_request_o <= 1'b0;
            red_chroma_dma_request_o  <= 1'b0;
            if (field_start_i) begin
                field2_active_r <= field2_i;
                if (field2_i)
                    requests_left_r <= display_dma_request_count_r
                        [`FIELD2_CNT_MSB:`FIELD2_CNT_LSB];
                else
                    requests_left_r <= display_dma_request_count_r
                        [`FIELD1_CNT_MSB:`FIELD1_CNT_LSB];
            end else if (need_taken) begin
                requests_left_r           <= requests_left_r - 12'h001;
                luma_dma_request_o        <= 1'b1;
                blue_chroma_dma_request_o <= !raw_mode;
                red_chroma_dma_request_o  <= !raw_mode;
            end
        end
    end

    // Bounds for this sample's component
    assign lo_bound = pix_chroma_i ?
        output_clip_bounds_r[`CHROMA_LO_MSB:`CHROMA_LO_LSB] :
        output_clip_bounds_r[`LUMA_LO_MSB:`LUMA_LO_LSB];
    assign hi_bound = pix_chroma_i ?
        output_clip_bounds_r[`CHROMA_HI_MSB:`CHROMA_HI_LSB] :
        output_clip_bounds_r[`LUMA_HI_MSB:`LUMA_HI_LSB];
    assign sample8     = pix_data_i[9:2];
    assign clip_active = !raw_mode && pix_image_i;

    // Clamp on the upper 8 bits
    // In-range samples keep their low bits, only clamped ones lose them
    always @* begin
        clamp8_nxt  = sample8;
        clamped_nxt = 1'b0;
        if (sample8 > hi_bound) begin
            clamp8_nxt  = hi_bound;
            clamped_nxt = 1'b1;
        end else if (sample8 < lo_bound) begin
            clamp8_nxt  = lo_bound;
            clamped_nxt = 1'b1;
        end
    end

    // Final output stage of the pixel path
    // Nothing follows this register, so clipping is the last step
    always @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pix_data_o  <= 10'h000;
            pix_valid_o <= 1'b0;
        end else begin
            pix_valid_o <= pix_valid_i;
            if (clip_active && clamped_nxt)
                pix_data_o <= {clamp8_nxt, 2'h0};
            else
                pix_data_o <= pix_data_i;
        end
    end

endmodule

`default_nettype wire

// >>> bench/display_reload_event_clip_checker.sv
`timescale 1ns/1ps
`default_nettype none
module display_reload_event_clip_checker #(
    parameter LINE_PIXELS = 12'd858,
    parameter FRAME_LINES = 12'd525
) (
    input wire logic        ref_clk_i,
    input wire logic        resetn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        field_start_i,
    input wire logic        dma_need_i,
    input wire logic        luma_dma_request_o,
    input wire logic        blue_chroma_dma_request_o,
    input wire logic        red_chroma_dma_request_o,
    input wire logic [9:0]  pix_data_i,
    input wire logic        pix_image_i,
    input wire logic        pix_valid_i,
    input wire logic [9:0]  pix_data_o,
    input wire logic        pix_valid_o
);
    // Core clock, quiet during reset
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    AST_READY_ONE_WAIT: assert property ($rose(penable_i) && psel_i |=> pready_o)
        else $error("ready late");
    AST_READY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("ready too long");
    AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    AST_IDLE_DATA: assert property (!pready_o |-> prdata_o == 32'h00000000)
        else $error("read data outside answer");
    AST_REQ_CAUSE: assert property (luma_dma_request_o |-> $past(dma_need_i) && !$past(field_start_i))
        else $error("request without cause");
    AST_REQ_SET: assert property (blue_chroma_dma_request_o || red_chroma_dma_request_o
        |-> luma_dma_request_o && blue_chroma_dma_request_o && red_chroma_dma_request_o)
        else $error("partial request set");
    AST_PIX_VALID: assert property ($past(resetn_i) |-> pix_valid_o == $past(pix_valid_i))
        else $error("valid not one cycle later");
    AST_BLANK_PASS: assert property ($past(pix_valid_i && !pix_image_i && resetn_i)
        |-> pix_data_o == $past(pix_data_i))
        else $error("blanking sample altered");
    AST_CLIP_LSB: assert property ($past(resetn_i) && pix_valid_o && pix_data_o != $past(pix_data_i)
        |-> pix_data_o[1:0] == 2'b00)
        else $error("clipped sample keeps low bits");
    // Main scenarios reached
    cover property (pslverr_o);
    cover property (blue_chroma_dma_request_o);
    cover property ($past(resetn_i) && pix_valid_o && pix_data_o != $past(pix_data_i));
endmodule
bind display_reload_event_clip display_reload_event_clip_checker #(
    .LINE_PIXELS(LINE_PIXELS), .FRAME_LINES(FRAME_LINES)) i_chk (.ref_clk_i, .resetn_i,
    .psel_i, .penable_i, .prdata_o, .pready_o, .pslverr_o, .field_start_i, .dma_need_i,
    .luma_dma_request_o, .blue_chroma_dma_request_o, .red_chroma_dma_request_o,
    .pix_data_i, .pix_image_i, .pix_valid_i, .pix_data_o, .pix_valid_o);
`default_nettype wire

// >>> bench/display_sink.sv
`timescale 1ns/1ps
`default_nettype none
module display_sink (
    input  wire logic       clk_i,
    input  wire logic       valid_i,
    input  wire logic [9:0] data_i,
    output var  logic [15:0] beats_o,
    output var  logic [9:0]  last_o
);
    initial beats_o = 16'h0000;
    // Encoder takes every valid sample
    always @(posedge clk_i) begin
        if (valid_i) begin
            beats_o <= beats_o + 16'h0001;
            last_o <= data_i;
        end
    end
endmodule
`default_nettype wire

// >>> bench/test_display_reload_event_clip.sv
`timescale 1ns/1ps
`default_nettype none
module test_display_reload_event_clip;
    logic ref_clk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic vid_clk_i = 1'b0, ext_hsync_i = 1'b0, ext_vsync_i = 1'b0, field_start_i = 1'b0;
    logic field2_i = 1'b0, dma_need_i = 1'b0, pix_chroma_i = 1'b0, pix_image_i = 1'b0;
    logic pix_valid_i = 1'b0, pready_o, pslverr_o, pix_valid_o, err;
    logic luma_dma_request_o, blue_chroma_dma_request_o, red_chroma_dma_request_o;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h00000000, prdata_o, rd;
    logic [9:0]  pix_data_i = 10'h000, pix_data_o;
    logic [15:0] beats, n_y = 16'h0000, n_c = 16'h0000;
    logic [9:0]  last_seen;
    int          n_fail = 0, compares = 0, n_pix = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    // Tally of request pulses; an unknown pulse poisons the tally
    always @(posedge ref_clk_i) begin
        if (resetn_i) begin
            n_y <= n_y + {15'h0, luma_dma_request_o};
            n_c <= n_c + {15'h0, blue_chroma_dma_request_o & red_chroma_dma_request_o};
        end
    end
    display_reload_event_clip #(.LINE_PIXELS(12'd8), .FRAME_LINES(12'd4)) i_dut (.ref_clk_i,
        .resetn_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o, .vid_clk_i, .ext_hsync_i, .ext_vsync_i, .field_start_i, .field2_i,
        .dma_need_i, .luma_dma_request_o, .blue_chroma_dma_request_o, .red_chroma_dma_request_o,
        .pix_data_i, .pix_chroma_i, .pix_image_i, .pix_valid_i, .pix_data_o, .pix_valid_o);
    display_sink i_sink (.clk_i(ref_clk_i), .valid_i(pix_valid_o), .data_i(pix_data_o),
        .beats_o(beats), .last_o(last_seen));
    task finish_test;
        if (n_fail == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        bit done;
        done = 1'b0;
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        for (int i = 0; i < 20 && !done; i++) begin
            @(posedge ref_clk_i);
            if (pready_o === 1'b1) begin
                rd = prdata_o;
                err = pslverr_o;
                done = 1'b1;
            end
        end
        if (!done) begin
            n_fail++;
            finish_test;
        end
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task sync(input logic h, input logic v);
        @(posedge ref_clk_i);
        ext_hsync_i <= h;
        ext_vsync_i <= v;
        repeat (4) @(posedge ref_clk_i);
        ext_hsync_i <= 1'b0;
        ext_vsync_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask
    task t_regs;
        apb(1'b0, 8'h08, 32'h0);
        chk("clip bounds reset", rd, 32'hF010EB10);
        apb(1'b1, 8'h00, 32'hFFFFFFFF);
        apb(1'b0, 8'h00, 32'h0);
        chk("reload reserved", rd, 32'h0FFFFFFF);
        apb(1'b1, 8'h04, 32'hFFFFFFFF);
        apb(1'b0, 8'h04, 32'h0);
        chk("count reserved", rd, 32'h0FFF0FFF);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped read", rd, 32'h0);
    endtask
    task t_reload;
        apb(1'b1, 8'h00, 32'h00025003);
        apb(1'b1, 8'h0C, 32'h0);
        sync(1'b1, 1'b1);
        apb(1'b0, 8'h14, 32'h0);
        chk("sync ignored", rd, 32'h0);
        apb(1'b1, 8'h0C, 32'hC);
        sync(1'b1, 1'b0);
        apb(1'b0, 8'h14, 32'h0);
        chk("hsync reload", rd, 32'h00005003);
        sync(1'b0, 1'b1);
        apb(1'b0, 8'h14, 32'h0);
        chk("vsync reload", rd, 32'h00025003);
        repeat (2) begin
            repeat (4) @(posedge ref_clk_i);
            vid_clk_i <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
            vid_clk_i <= 1'b0;
        end
        apb(1'b0, 8'h14, 32'h0);
        chk("count resumes", rd, 32'h00027005);
    endtask
    task t_req(input logic [1:0] mode, input logic f2, input int ey, input int ec);
        logic [15:0] y0, c0;
        apb(1'b1, 8'h0C, {30'h0, mode});
        y0 = n_y;
        c0 = n_c;
        @(posedge ref_clk_i);
        field_start_i <= 1'b1;
        field2_i <= f2;
        dma_need_i <= 1'b1;
        @(posedge ref_clk_i);
        field_start_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        dma_need_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chk("luma requests", {16'h0, n_y - y0}, ey);
        chk("chroma sets", {16'h0, n_c - c0}, ec);
    endtask
    task t_pix(input logic [9:0] d, input logic c, input logic img, input logic [9:0] e);
        @(posedge ref_clk_i);
        pix_data_i <= d;
        pix_chroma_i <= c;
        pix_image_i <= img;
        pix_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        pix_valid_i <= 1'b0;
        @(negedge ref_clk_i);
        chk("pixel out", {22'h0, pix_data_o}, {22'h0, e});
        n_pix++;
    endtask
    task t_clip;
        apb(1'b1, 8'h0C, 32'h0);
        t_pix(10'h3FE, 1'b0, 1'b1, 10'h3AC);
        t_pix(10'h03D, 1'b0, 1'b1, 10'h040);
        t_pix(10'h3FF, 1'b1, 1'b1, 10'h3C0);
        t_pix(10'h000, 1'b1, 1'b1, 10'h040);
        t_pix(10'h201, 1'b0, 1'b1, 10'h201);
        t_pix(10'h3FE, 1'b0, 1'b0, 10'h3FE);
        apb(1'b1, 8'h0C, 32'h1);
        t_pix(10'h3FE, 1'b0, 1'b1, 10'h3AC);
        apb(1'b1, 8'h0C, 32'h2);
        t_pix(10'h3FE, 1'b0, 1'b1, 10'h3FE);
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b1, 8'h08, 32'h80208020);
        t_pix(10'h3FE, 1'b0, 1'b1, 10'h200);
        t_pix(10'h000, 1'b1, 1'b1, 10'h080);
    endtask
    initial begin
        repeat (10) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        t_regs;
        t_reload;
        apb(1'b1, 8'h04, 32'h00020003);
        t_req(2'h0, 1'b0, 3, 3);
        t_req(2'h1, 1'b1, 2, 2);
        t_req(2'h2, 1'b0, 3, 0);
        t_clip;
        repeat (2) @(posedge ref_clk_i);
        chk("sink beats", {16'h0, beats}, n_pix);
        chk("sink last", {22'h0, last_seen}, 32'h00000080);
        finish_test;
    end
endmodule
`default_nettype wire
